//--- rtl/paddle_scan_pkg.sv
// paddle_scan_pkg: register map, field positions and timing counts
// for the paddle position scanner. assumes a 25 MHz system clock.
package paddle_scan_pkg;

  // ----------------------------------------
  // register byte addresses (one word each)
  // ----------------------------------------
  localparam logic [7:0] POS_BASE_ADDR   = 8'h00; // eight position words
  localparam logic [7:0] PENDING_ADDR    = 8'h20;
  localparam logic [7:0] START_ADDR      = 8'h24;
  localparam logic [7:0] CONTROL_ADDR    = 8'h28;
  localparam logic [7:0] COUNTER_ADDR    = 8'h2C;
  localparam logic [7:0] LAST_ADDR       = 8'h2C;

  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int         CTRL_RUN_BIT    = 0; // 0 = initialization mode
  localparam int         CTRL_FAST_BIT   = 2;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;

  // ----------------------------------------
  // counter limits
  // ----------------------------------------
  localparam int         NUM_POTS        = 8;
  localparam logic [7:0] STOP_NORMAL     = 8'hE4; // 228
  localparam logic [7:0] STOP_FAST       = 8'hE5; // 229
  localparam logic [7:0] COUNT_RESET     = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ       = 25_000_000;
  localparam int SCAN_TICK_HZ = 15_000;
  localparam int MACHINE_HZ   = 1_790_000;
  localparam int SLOW_CYC     = CLK_HZ / SCAN_TICK_HZ;
  localparam int FAST_CYC     = CLK_HZ / MACHINE_HZ;

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : paddle_scan_pkg

//--- rtl/scan_tick_if.sv
// scan_tick_if: carries the count ticks from the tick generator
// to the scanner. assumes both ends run on the same clock.
`timescale 1ns/1ps
interface scan_tick_if;
  logic clock_run;  // low while initialization mode freezes the clock
  logic slow_tick;  // one pulse per scan line
  logic fast_tick;  // one pulse per machine cycle

  modport gen
  (
    input  clock_run,
    output slow_tick,
    output fast_tick
  );
  modport use_side
  (
    output clock_run,
    input  slow_tick,
    input  fast_tick
  );
endinterface : scan_tick_if

//--- rtl/scan_tick_gen.sv
// scan_tick_gen: divides aclk down to the scan-line tick and the
// machine-cycle tick. assumes aclk at 25 MHz, synchronous reset.
`timescale 1ns/1ps
module scan_tick_gen
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  scan_tick_if.gen   ticks
);

  logic [10:0] slow_div;
  logic [3:0]  fast_div;

  // ----------------------------------------
  // scan-line divider; halts in initialization mode
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      slow_div <= 11'h000;
    else if (ticks.clock_run)
      slow_div <= (slow_div == 11'(paddle_scan_pkg::SLOW_CYC - 1)) ? 11'h000
                                                                  : slow_div + 11'h001;
  end

  // machine clock keeps running whatever the mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fast_div <= 4'h0;
    else
      fast_div <= (fast_div == 4'(paddle_scan_pkg::FAST_CYC - 1)) ? 4'h0
                                                                 : fast_div + 4'h1;
  end

  assign ticks.slow_tick = ticks.clock_run
                           && (slow_div == 11'(paddle_scan_pkg::SLOW_CYC - 1));
  assign ticks.fast_tick = (fast_div == 4'(paddle_scan_pkg::FAST_CYC - 1));

endmodule : scan_tick_gen

//--- rtl/paddle_pot_scan.sv
// paddle_pot_scan: eight-input paddle position scanner behind an
// AXI4-Lite slave. assumes comparator inputs are asynchronous levels
// (high = capacitor at or above threshold) and one 25 MHz clock.
//
// Notes on behaviour
// - start write clears counter, then counts ticks
// - pending inputs copy the shared counter
// - normal mode counter stops at 228
// - normal mode counts scan-line ticks, frozen by init
// - pending flags: 1 while input still timed
// - pending flags forced zero once scan stops
// - input dropping below threshold resumes tracking
// - control bit 2 selects machine-clock fast mode
// - fast mode counter stops at 229
// - fast mode keeps dump transistors off
// - dump on only in slow mode, idle
// - input already above threshold stays unchanged
// - full scan length fixed; restart skips dump
// - live position values even, final may be odd
// - init mode only freezes slow clock
`timescale 1ns/1ps
module paddle_pot_scan
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pot_above,
  output logic             dump_on
);

  scan_tick_if ticks ();

  logic [7:0]  control;
  logic [7:0]  count;
  logic        scanning;
  logic [7:0]  above_meta;
  logic [7:0]  above_sync;
  logic [7:0]  pending;
  logic [7:0]  pos [paddle_scan_pkg::NUM_POTS];
  logic        fast;
  logic        tick;
  logic [7:0]  stop_value;
  logic [7:0]  next_count;
  logic        final_tick;
  logic        start_write;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic        aw_out;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic [31:0] read_word;
  logic        read_bad;

  // ----------------------------------------
  // tick generation
  // ----------------------------------------
  scan_tick_gen i_scan_tick_gen
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ticks   (ticks.gen)
  );

  // init mode stops only the scan-line clock; nothing else is cleared
  assign ticks.clock_run = control[paddle_scan_pkg::CTRL_RUN_BIT];

  assign fast       = control[paddle_scan_pkg::CTRL_FAST_BIT];
  assign tick       = fast ? ticks.fast_tick
                           : ticks.slow_tick;
  assign stop_value = fast ? paddle_scan_pkg::STOP_FAST
                           : paddle_scan_pkg::STOP_NORMAL;
  assign next_count = count + 8'h01;
  assign final_tick = scanning && tick && (next_count >= stop_value);

  // ----------------------------------------
  // comparator synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      above_meta <= 8'h00;
      above_sync <= 8'h00;
    end
    else
    begin
      above_meta <= pot_above;
      above_sync <= above_meta;
    end
  end

  // ----------------------------------------
  // shared scan counter
  // ----------------------------------------
  // a restart during a scan simply reloads; no dump interval is inserted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count    <= paddle_scan_pkg::COUNT_RESET;
      scanning <= 1'b0;
    end
    else if (start_write)
    begin
      count    <= 8'h00;
      scanning <= 1'b1;
    end
    else if (scanning && tick)
    begin
      count <= final_tick ? stop_value : next_count;
      if (final_tick)
        scanning <= 1'b0;
    end
  end

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // follow the comparators live, so a dip below threshold re-arms
  assign pending = scanning ? ~above_sync : 8'h00;

  // dump transistors only drain between slow scans
  assign dump_on = !fast && !scanning;

  // ----------------------------------------
  // position registers, one per input
  // ----------------------------------------
  // live copies drop bit 0 so a reader mid-scan never sees odd counts;
  // the value written on the stopping tick keeps its full width
  for (genvar i = 0; i < paddle_scan_pkg::NUM_POTS; i++)
  begin : g_pos
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pos[i] <= paddle_scan_pkg::COUNT_RESET;
      else if (final_tick && pending[i])
        pos[i] <= stop_value;
      else if (pending[i] && !start_write)
        pos[i] <= {count[7:1], 1'b0};
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // address and data may arrive in either order; each is held until both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      aw_out  <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr[7:0];
      // upper bits are remembered so an alias can never start a scan
      aw_out  <= (s_axi_awaddr[31:8] != 24'h000000);
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // the strobe fires on any write to its word, whatever the data
  assign start_write = do_write && !aw_out && (aw_addr == paddle_scan_pkg::START_ADDR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control <= paddle_scan_pkg::CONTROL_RESET;
    else if (do_write && !aw_out && aw_addr == paddle_scan_pkg::CONTROL_ADDR && w_strb[0])
      control <= w_data[7:0];
  end

  // write response; unmapped or unaligned words answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= paddle_scan_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_out || aw_addr > paddle_scan_pkg::LAST_ADDR || aw_addr[1:0] != 2'h0)
                      ? paddle_scan_pkg::RESP_SLVERR : paddle_scan_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_bad  = 1'b0;
    if (s_axi_araddr[31:8] != 24'h000000 || s_axi_araddr[1:0] != 2'h0)
      read_bad = 1'b1;
    else if (s_axi_araddr[7:0] < paddle_scan_pkg::PENDING_ADDR)
      read_word = {24'h000000, pos[s_axi_araddr[4:2]]};
    else
      unique case (s_axi_araddr[7:0])
        paddle_scan_pkg::PENDING_ADDR: read_word = {24'h000000, pending};
        paddle_scan_pkg::START_ADDR:   read_word = 32'h0000_0000;
        paddle_scan_pkg::CONTROL_ADDR: read_word = {24'h000000, control};
        paddle_scan_pkg::COUNTER_ADDR: read_word = {23'h0, scanning, count};
        default:                       read_bad  = 1'b1;
      endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= paddle_scan_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word;
      s_axi_rresp  <= read_bad ? paddle_scan_pkg::RESP_SLVERR
                               : paddle_scan_pkg::RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // input 0 stands in for all eight, as the per-input logic is one loop
  chk_start_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    start_write |=> (count == 8'h00) && scanning)
    else $error("start write did not clear the counter");

  chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && tick && !final_tick && !start_write |=> count == $past(count) + 8'h01)
    else $error("counter did not step by one");

  chk_stop_normal: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && tick && !fast && count == 8'hE3 && !start_write
    |=> !scanning && count == 8'hE4 ##1 count == 8'hE4 || start_write)
    else $error("normal scan did not stop at 228");

  chk_stop_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && tick && fast && count == 8'hE4 && !start_write
    |=> !scanning && count == 8'hE5)
    else $error("fast scan did not stop at 229");

  chk_init_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !control[0] && !fast && !start_write |=> $stable(count))
    else $error("counter moved while initialization froze its clock");

  chk_flags_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(scanning) |-> pending == 8'h00)
    else $error("pending flags not cleared at scan end");

  chk_dump_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    fast |-> !dump_on)
    else $error("dump on in fast mode");

  chk_dump_scan: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(scanning) |-> !dump_on ##1 (!dump_on || !scanning))
    else $error("dump on during a scan");

  chk_hold_above: assert property (@(posedge aclk) disable iff (!aresetn)
    !pending[0] && !final_tick |=> $stable(pos[0]))
    else $error("position changed for an input above threshold");

  chk_live_even: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && pending[0] && !final_tick && !start_write |=> pos[0][0] == 1'b0)
    else $error("live position value was odd");

  chk_track_count: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && pending[0] && !final_tick && !start_write
    |=> pos[0][7:1] == $past(count[7:1]))
    else $error("pending position did not track the counter");

  chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !scanning && !start_write |=> $stable(count))
    else $error("counter moved while no scan was running");

  chk_final_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    final_tick && pending[0] |=> pos[0] == $past(stop_value))
    else $error("stop value not latched into a pending position");

  chk_restart_nodump: assert property (@(posedge aclk) disable iff (!aresetn)
    scanning && start_write |=> scanning && count == 8'h00 && !dump_on)
    else $error("restart during a scan let the dump transistors on");

endmodule : paddle_pot_scan

//--- test/pot_model.sv
// pot_model: eight paddle pots charging their timing capacitors.
// assumes dump_on from the scanner and the same aclk.
`timescale 1ns/1ps
module pot_model
(
  input  wire logic       aclk,
  input  wire logic       dump_on,
  input  wire logic [7:0] pull_low,
  output logic      [7:0] pot_above
);
  // ----------------------------------------
  // capacitor charge state
  // ----------------------------------------
  localparam int DRAIN_CYC = 30; // a cap is only empty after a full drain
  logic [15:0] level [8];
  int          dump_run;

  initial
  begin
    dump_run = 0;
    foreach (level[i]) level[i] = 16'h0000;
  end

  // charge while dump is off; a short dump pulse leaves the charge in place
  always @(posedge aclk)
  begin
    dump_run <= (dump_on === 1'b1) ? dump_run + 1 : 0;
    for (int i = 0; i < 8; i++)
    begin
      if (dump_run >= DRAIN_CYC)
        level[i] <= 16'h0000;
      else if (dump_on === 1'b0 && level[i] != 16'hFFFF)
        level[i] <= level[i] + 16'h0001;
    end
  end

  // pot i crosses after 260*(i+1) cycles; pot 7 is unconnected, never crosses
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pot_above[i] = !pull_low[i] && i < 7 && level[i] >= 16'(260 * (i + 1));
  end
endmodule : pot_model

//--- test/paddle_pot_scan_bench.sv
// paddle_pot_scan_bench: register-level tests of the paddle scanner.
// assumes the pot model on the comparator inputs and a 25 MHz aclk.
`timescale 1ns/1ps
module paddle_pot_scan_bench;
  localparam logic [7:0] a_pos   = paddle_scan_pkg::POS_BASE_ADDR;
  localparam logic [7:0] a_pend  = paddle_scan_pkg::PENDING_ADDR;
  localparam logic [7:0] a_start = paddle_scan_pkg::START_ADDR;
  localparam logic [7:0] a_ctl   = paddle_scan_pkg::CONTROL_ADDR;
  localparam logic [7:0] a_cnt   = paddle_scan_pkg::COUNTER_ADDR;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, dump_on;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  logic [7:0]  pull_low = 8'h00, pot_above;
  int          err_total = 0, check_count = 0;

  paddle_pot_scan i_paddle_pot_scan
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pot_above(pot_above), .dump_on(dump_on)
  );
  pot_model i_pot_model
  (
    .aclk(aclk), .dump_on(dump_on), .pull_low(pull_low), .pot_above(pot_above)
  );

  initial
  begin
    forever #20 aclk = ~aclk;
  end

  // ----------------------------------------
  // verdict and compares
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  // counts that depend on divider phase get a window, not a value
  task automatic check_range(input logic [31:0] got, input int lo, input int hi);
    check_count++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic timeout_hit;
    err_total++;
    report_and_stop();
  endtask : timeout_hit

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= {24'h000000, a};
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 100 && bvalid !== 1'b1)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n >= 100) timeout_hit();
    check_val({30'h0, bresp}, {30'h0, paddle_scan_pkg::RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= {24'h000000, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 100 && rvalid !== 1'b1)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 100) timeout_hit();
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check_val(d, exp);
    check_val({30'h0, r}, {30'h0, paddle_scan_pkg::RESP_OKAY});
  endtask : rd_chk

  task automatic rd_rng(input logic [7:0] a, input int lo, input int hi);
    rd(a);
    check_range(d, lo, hi);
  endtask : rd_rng

  task automatic dump_is(input logic exp);
    #1;
    check_val({31'h0, dump_on}, {31'h0, exp});
  endtask : dump_is

  task automatic wait_idle;
    int n;
    n = 0;
    d = 32'h100;
    while (n < 1500 && d[8] !== 1'b0)
    begin
      rd(a_cnt);
      n++;
    end
    if (n >= 1500) timeout_hit();
  endtask : wait_idle

  // fast-scan positions of pots 1..6: about 20 counts per pot step
  task automatic fast_positions;
    for (int i = 1; i < 7; i++)
      rd_rng(a_pos + 8'(4 * i), 20 * (i + 1) - 4, 20 * (i + 1) + 2);
  endtask : fast_positions

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    dump_is(1'b1);
    rd_chk(a_ctl, 32'h0);
    rd(8'h30);
    check_val({30'h0, r}, {30'h0, paddle_scan_pkg::RESP_SLVERR});
    wr(a_pend, 32'hFF);
    rd_chk(a_pend, 32'h0);
    // slow scan, then freeze by initialization mode
    wr(a_ctl, 32'h01);
    rd_chk(a_ctl, 32'h01);
    repeat (40) @(posedge aclk);
    wr(a_start, 32'h0);
    dump_is(1'b0);
    rd_chk(a_pend, 32'hFF);
    repeat (4000) @(posedge aclk);
    rd_rng(a_cnt, 32'h102, 32'h103);
    rd_chk(a_pend, 32'h80);
    rd_chk(a_pos + 8'h1C, 32'h2);
    rd_chk(a_pos, 32'h0);
    wr(a_ctl, 32'h00);
    repeat (4000) @(posedge aclk);
    rd_rng(a_cnt, 32'h102, 32'h103);
    wr(a_start, 32'h0);
    rd_chk(a_cnt, 32'h100);
    dump_is(1'b0);
    // second reset in mid-scan, driven on the clock edge like every input
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    dump_is(1'b1);
    rd_chk(a_cnt, 32'h0);
    repeat (40) @(posedge aclk);
    // fast scan with one input dipping back below threshold
    wr(a_ctl, 32'h04);
    dump_is(1'b0);
    wr(a_start, 32'h0);
    rd_chk(a_pend, 32'hFF);
    repeat (400) @(posedge aclk);
    rd_chk(a_pend, 32'hFE);
    pull_low <= 8'h01;
    repeat (10) @(posedge aclk);
    rd_chk(a_pend, 32'hFF);
    wait_idle();
    rd_chk(a_cnt, 32'hE5);
    rd_chk(a_pend, 32'h0);
    rd_chk(a_pos, 32'hE5);
    rd_chk(a_pos + 8'h1C, 32'hE5);
    fast_positions();
    // restart with caps still charged: no dump in fast mode
    pull_low <= 8'h00;
    repeat (4) @(posedge aclk);
    wr(a_start, 32'h0);
    dump_is(1'b0);
    rd_chk(a_pend, 32'h80);
    wait_idle();
    rd_chk(a_pos, 32'hE5);
    fast_positions();
    report_and_stop();
  end
endmodule : paddle_pot_scan_bench
